// *** verilog/ckepd_consts.svh ***
// timing counts and widths for the cke power-down sequencer
`ifndef CKEPD_CONSTS_SVH
`define CKEPD_CONSTS_SVH
`define CKEPD_NUM_CKE 2
`define CKEPD_NUM_CS 4
`define CKEPD_NUM_ODT 2
`define CKEPD_ADDR_W 22
`define CKEPD_IN_DIS_CLKS 4
`define CKEPD_OUT_FLOAT_CLKS 1
`define CKEPD_FIXED_OUT_CLKS 8
`define CKEPD_ACT_CLKS 16
`define CKEPD_STOP_DET_CLKS 8
`define CKEPD_CNT_W 8
`endif

// *** verilog/ckepd_pkg.sv ***
// types for the cke power-down sequencer
`default_nettype none
package ckepd_pkg;
	typedef enum logic [2:0] {
		CKEPD_RUN,
		CKEPD_ENTER,
		CKEPD_DOWN,
		CKEPD_FIXED,
		CKEPD_CLKSTOP,
		CKEPD_WAKE
	} ckepd_state_t;
	typedef struct packed {
		logic [3:0] chip_select;
		logic [1:0] odt;
		logic [1:0] cke;
		logic [21:0] address;
	} ckepd_cmd_t;
	typedef struct packed {
		logic cmd;
		logic parity;
		logic odt;
		logic termination;
	} ckepd_rx_en_t;
endpackage
`default_nettype wire

// *** verilog/ckepd_clock_watch.sv ***
// detects a stopped input clock from its sampled level
`include "ckepd_consts.svh"
`default_nettype none
module ckepd_clock_watch
#(
	parameter int STOP_CLKS = `CKEPD_STOP_DET_CLKS
)
(
	input wire logic clk_sys_in,
	input wire logic reset_in,
	input wire logic ck_level_in,
	output logic stopped_out,
	output logic toggle_out
);
	logic sync1_reg;
	logic sync2_reg;
	logic last_reg;
	logic [`CKEPD_CNT_W-1:0] low_reg;
	logic [`CKEPD_CNT_W-1:0] low_next;
	logic stopped_reg;
	logic stopped_next;
	always_comb
	begin
		low_next = low_reg;
		stopped_next = stopped_reg;
		if (sync2_reg)
		begin
			low_next = '0;
			stopped_next = 1'b0;
		end
		else if (low_reg == STOP_CLKS[`CKEPD_CNT_W-1:0])
			stopped_next = 1'b1;
		else
			low_next = low_reg + 1'b1;
	end
	always_ff @(posedge clk_sys_in)
	begin
		if (reset_in)
		begin
			sync1_reg <= 1'b0;
			sync2_reg <= 1'b0;
			last_reg <= 1'b0;
			low_reg <= '0;
			stopped_reg <= 1'b0;
		end
		else
		begin
			sync1_reg <= ck_level_in;
			sync2_reg <= sync1_reg;
			last_reg <= sync2_reg;
			low_reg <= low_next;
			stopped_reg <= stopped_next;
		end
	end
	assign stopped_out = stopped_reg;
	assign toggle_out = sync2_reg & ~last_reg;
endmodule
`default_nettype wire

// *** verilog/ckepd_sequencer.sv ***
// cke and clock-stopped power-down sequencer of a registering clock driver
// Behaviour
// RQ1: enable bit, both cke low after fall: enter
// RQ2: termination bit picks termination off or on
// RQ3: command with cke falling forwarded, cke low
// RQ4: termination off: disable inputs and termination
// RQ5: inputs disabled within input disable delay
// RQ6: parity receiver stays one clock longer
// RQ7: outputs off except clocks, odt, cke
// RQ8: outputs float output-float delay after cke low
// RQ9: cke output follows rising cke input at once
// RQ10: termination-off exit: cs high, odt low
// RQ11: fixed levels held, then outputs follow
// RQ12: chip select held high one clock
// RQ13: controller drives valid levels on exit
// RQ14: controller asserts one cs for one clock
// RQ15: controller never drives both cs low
// RQ16: termination on: odt receiver stays enabled
// RQ17: termination-on exit: odt tracks input
// RQ18: clock stopped: float all, cke low
// RQ19: clock stop only after self refresh
// RQ20: controller keeps cke low before clock stop
// RQ21: controller holds cke after clock stop
// RQ22: wake with cs high, cke low
// RQ23: outputs follow inputs within activation time
// RQ24: controller waits stabilisation before access
// RQ25: reset overrides every power-down state
`include "ckepd_consts.svh"
`default_nettype none
module ckepd_sequencer
	import ckepd_pkg::*;
#(
	parameter int IN_DIS_CLKS = `CKEPD_IN_DIS_CLKS,
	parameter int OUT_FLOAT_CLKS = `CKEPD_OUT_FLOAT_CLKS,
	parameter int FIXED_OUT_CLKS = `CKEPD_FIXED_OUT_CLKS,
	parameter int ACT_CLKS = `CKEPD_ACT_CLKS
)
(
	input wire logic clk_sys_in,
	input wire logic reset_in,
	input wire logic ck_level_in,
	input wire logic power_down_enable_bit_in,
	input wire logic termination_select_bit_in,
	input wire ckepd_pkg::ckepd_cmd_t cmd_in,
	output ckepd_pkg::ckepd_cmd_t cmd_out,
	output logic cmd_oe_out,
	output logic cke_oe_out,
	output logic odt_oe_out,
	output logic dram_clock_en_out,
	output ckepd_pkg::ckepd_rx_en_t rx_en_out,
	output logic pll_run_out
);
	import ckepd_pkg::*;
	ckepd_state_t state_reg;
	ckepd_state_t state_next;
	ckepd_cmd_t cmd_reg;
	ckepd_cmd_t cmd_next;
	ckepd_cmd_t prev_reg;
	logic [`CKEPD_CNT_W-1:0] cnt_reg;
	logic [`CKEPD_CNT_W-1:0] cnt_next;
	logic cmd_oe_reg;
	logic cmd_oe_next;
	logic term_on_reg;
	logic term_on_next;
	ckepd_rx_en_t rx_reg;
	ckepd_rx_en_t rx_next;
	logic cs_hold_reg;
	logic cs_hold_next;
	logic clk_stopped;
	logic clk_edge;
	logic cke_fell;
	logic cke_any;

	ckepd_clock_watch ckepd_clock_watch_i
	(
		.clk_sys_in(clk_sys_in),
		.reset_in(reset_in),
		.ck_level_in(ck_level_in),
		.stopped_out(clk_stopped),
		.toggle_out(clk_edge)
	);

	function automatic logic [`CKEPD_CNT_W-1:0] clks(input int n);
		clks = (n < 1) ? `CKEPD_CNT_W'(1) : `CKEPD_CNT_W'(n);
	endfunction

	assign cke_any = |cmd_in.cke;
	assign cke_fell = |(prev_reg.cke & ~cmd_in.cke);

	always_comb
	begin
		state_next = state_reg;
		cmd_next = cmd_in;
		cnt_next = (cnt_reg != '0) ? cnt_reg - 1'b1 : cnt_reg;
		cmd_oe_next = cmd_oe_reg;
		term_on_next = term_on_reg;
		rx_next = rx_reg;
		cs_hold_next = 1'b0;
		case (state_reg)
			CKEPD_RUN:
			begin
				cmd_oe_next = 1'b1;
				rx_next = '1;
				if (power_down_enable_bit_in && !cke_any && cke_fell) // RQ1
				begin
					state_next = CKEPD_ENTER;
					term_on_next = termination_select_bit_in; // RQ2
					cnt_next = clks(IN_DIS_CLKS);
					// command passes with cke low this once
					cmd_next = cmd_in; // RQ3
				end
			end
			CKEPD_ENTER:
			begin
				cmd_next = cmd_reg;
				cmd_next.cke = '0;
				cmd_next.odt = term_on_reg ? cmd_in.odt : '0; // RQ7
				// float counts from the cke drop, not from the receiver shutdown
				if (cnt_reg == clks(IN_DIS_CLKS + 1 - OUT_FLOAT_CLKS))
					cmd_oe_next = 1'b0; // RQ8
				if (cnt_reg == `CKEPD_CNT_W'(1))
				begin
					rx_next.cmd = 1'b0; // RQ5
					rx_next.odt = term_on_reg; // RQ16
					rx_next.termination = term_on_reg; // RQ4
				end
				if (cnt_reg == '0)
				begin
					// parity off one clock after the address receivers
					rx_next.parity = 1'b0; // RQ6
					cmd_oe_next = 1'b0; // RQ8
					state_next = CKEPD_DOWN;
				end
				if (cke_any)
				begin
					state_next = CKEPD_FIXED;
					cnt_next = clks(FIXED_OUT_CLKS);
					rx_next = '1;
					cmd_oe_next = 1'b1;
					cmd_next.cke = cmd_in.cke; // RQ9
					cmd_next.chip_select = '1; // RQ12
				end
			end
			CKEPD_DOWN:
			begin
				cmd_next = cmd_reg;
				cmd_next.cke = '0;
				cmd_next.odt = term_on_reg ? cmd_in.odt : '0; // RQ17
				if (clk_stopped)
				begin
					state_next = CKEPD_CLKSTOP; // RQ18
					rx_next = '0;
				end
				else if (cke_any)
				begin
					state_next = CKEPD_FIXED;
					cnt_next = clks(FIXED_OUT_CLKS);
					rx_next = '1;
					cmd_oe_next = 1'b1;
					cmd_next.cke = cmd_in.cke; // RQ9
					cmd_next.chip_select = '1; // RQ12
					cmd_next.odt = term_on_reg ? cmd_in.odt : '0; // RQ10
				end
			end
			CKEPD_FIXED:
			begin
				// fixed levels keep dram inputs valid while receivers settle
				cmd_next = cmd_reg;
				cmd_next.cke = cmd_in.cke; // RQ9
				cmd_next.chip_select = cmd_in.chip_select; // RQ12
				cmd_next.odt = term_on_reg ? cmd_in.odt : '0; // RQ17
				rx_next = '1;
				cmd_oe_next = 1'b1;
				if (cnt_reg == '0)
					state_next = CKEPD_RUN; // RQ11
			end
			CKEPD_CLKSTOP:
			begin
				cmd_next = '0;
				cmd_oe_next = 1'b0;
				rx_next = '0;
				if (clk_edge)
				begin
					state_next = CKEPD_WAKE;
					cnt_next = clks(ACT_CLKS);
				end
			end
			CKEPD_WAKE:
			begin
				cmd_next = '0;
				rx_next = '1;
				if (cnt_reg == '0)
				begin
					// wakes with cke low, still in cke power down
					state_next = CKEPD_DOWN; // RQ23
					rx_next = {2'b00, term_on_reg, term_on_reg}; // RQ4
					cmd_oe_next = 1'b0;
				end
			end
			default:
				state_next = CKEPD_RUN;
		endcase
		if ((state_reg == CKEPD_DOWN || state_reg == CKEPD_ENTER) && state_next == CKEPD_FIXED)
			cs_hold_next = 1'b1;
	end

	always_ff @(posedge clk_sys_in)
	begin
		if (reset_in) // RQ25
		begin
			state_reg <= CKEPD_RUN;
			cmd_reg <= '0;
			prev_reg <= '0;
			cnt_reg <= '0;
			cmd_oe_reg <= 1'b0;
			term_on_reg <= 1'b0;
			rx_reg <= '0;
			cs_hold_reg <= 1'b0;
		end
		else
		begin
			state_reg <= state_next;
			cmd_reg <= cmd_next;
			prev_reg <= cmd_in;
			cnt_reg <= cnt_next;
			cmd_oe_reg <= cmd_oe_next;
			term_on_reg <= term_on_next;
			rx_reg <= rx_next;
			cs_hold_reg <= cs_hold_next;
		end
	end

	assign cmd_out = cmd_reg;
	assign cmd_oe_out = cmd_oe_reg;
	// cke stays driven even with the clock stopped
	assign cke_oe_out = 1'b1; // RQ18
	assign odt_oe_out = (state_reg != CKEPD_CLKSTOP); // RQ7
	assign dram_clock_en_out = (state_reg != CKEPD_CLKSTOP);
	assign pll_run_out = (state_reg != CKEPD_CLKSTOP);
	assign rx_en_out = rx_reg;

	property p_enter;
		@(posedge clk_sys_in) disable iff (reset_in)
		(state_reg == CKEPD_RUN && power_down_enable_bit_in && !cke_any && cke_fell) |=> state_reg == CKEPD_ENTER;
	endproperty
	a_enter: assert property (p_enter) else $error("no power-down entry"); // RQ1

	property p_cke_low;
		@(posedge clk_sys_in) disable iff (reset_in)
		(state_reg == CKEPD_ENTER) |-> cmd_reg.cke == '0;
	endproperty
	a_cke_low: assert property (p_cke_low) else $error("cke out not low in entry"); // RQ3

	property p_rx_off;
		@(posedge clk_sys_in) disable iff (reset_in)
		$rose(state_reg == CKEPD_ENTER) |-> ##[1:IN_DIS_CLKS] (!rx_reg.cmd || state_reg == CKEPD_FIXED);
	endproperty
	a_rx_off: assert property (p_rx_off) else $error("receivers not disabled"); // RQ5

	property p_parity_late;
		@(posedge clk_sys_in) disable iff (reset_in)
		($fell(rx_reg.cmd) && state_reg == CKEPD_ENTER) |-> rx_reg.parity;
	endproperty
	a_parity_late: assert property (p_parity_late) else $error("parity receiver off early"); // RQ6

	property p_term;
		@(posedge clk_sys_in) disable iff (reset_in)
		(state_reg == CKEPD_DOWN) |-> rx_reg.termination == term_on_reg && rx_reg.odt == term_on_reg;
	endproperty
	a_term: assert property (p_term) else $error("termination state wrong"); // RQ4

	property p_float;
		@(posedge clk_sys_in) disable iff (reset_in)
		(state_reg == CKEPD_DOWN) |-> !cmd_oe_reg;
	endproperty
	a_float: assert property (p_float) else $error("outputs not floated"); // RQ8

	property p_odt_off;
		@(posedge clk_sys_in) disable iff (reset_in)
		(state_reg == CKEPD_DOWN && !term_on_reg) |-> cmd_reg.odt == '0;
	endproperty
	a_odt_off: assert property (p_odt_off) else $error("odt not low"); // RQ7

	property p_cs_high;
		@(posedge clk_sys_in) disable iff (reset_in)
		cs_hold_reg |-> cmd_reg.chip_select == '1 ##1 state_reg != CKEPD_DOWN;
	endproperty
	a_cs_high: assert property (p_cs_high) else $error("cs not held on exit"); // RQ12

	property p_fixed_end;
		@(posedge clk_sys_in) disable iff (reset_in)
		$rose(state_reg == CKEPD_FIXED) |-> ##[1:300] state_reg != CKEPD_FIXED;
	endproperty
	a_fixed_end: assert property (p_fixed_end) else $error("fixed hold never ends"); // RQ11

	property p_stop;
		@(posedge clk_sys_in) disable iff (reset_in)
		(state_reg == CKEPD_CLKSTOP) |-> cmd_reg.cke == '0 && !cmd_oe_reg && !pll_run_out;
	endproperty
	a_stop: assert property (p_stop) else $error("clock stop outputs wrong"); // RQ18
endmodule
`default_nettype wire

// *** verification/ckepd_ctrl_model.sv ***
// memory controller model driving command lines and input clock level
`default_nettype none
module ckepd_ctrl_model
(
	input wire logic clk_sys_in,
	output ckepd_pkg::ckepd_cmd_t cmd_out,
	output logic ck_level_out
);
	timeunit 1ns;
	timeprecision 1ns;
	import ckepd_pkg::*;
	logic ck_run = 1'b1;
	initial cmd_out = '1;
	initial ck_level_out = 1'b0;
	// stopped clock sits low, as its pull-down would leave it
	always @(posedge clk_sys_in)
	begin
		#1;
		ck_level_out = ck_run ? ~ck_level_out : 1'b0;
	end
	task put(input ckepd_cmd_t c);
		cmd_out = c;
	endtask
	task stop_clock(input int n);
		repeat (4) @(posedge clk_sys_in);
		#1;
		ck_run = 1'b0;
		cmd_out.address = ~cmd_out.address;
		repeat (n) @(posedge clk_sys_in);
		#1;
	endtask
	task wake(input int n);
		cmd_out.chip_select = '1;
		cmd_out.cke = '0;
		ck_run = 1'b1;
		repeat (n) @(posedge clk_sys_in);
		#1;
	endtask
endmodule
`default_nettype wire

// *** verification/ckepd_sequencer_tb.sv ***
// self-checking bench for the cke power-down sequencer
`default_nettype none
module ckepd_sequencer_tb;
	timeunit 1ns;
	timeprecision 1ns;
	import ckepd_pkg::*;
	typedef struct {
		int due;
		logic [38:0] v;
		logic [38:0] m;
	} ckepd_note_t;
	localparam logic [38:0] M_ALL = '1;
	localparam logic [38:0] M_CS = 39'h7800000000;
	localparam logic [38:0] M_ODT = 39'h0600000000;
	localparam logic [38:0] M_CKE = 39'h0180000000;
	logic clk_sys_in = 1'b0;
	logic reset_in = 1'b1;
	logic pd_en = 1'b1;
	logic term_on = 1'b0;
	logic ck_level;
	ckepd_cmd_t cmd_in;
	ckepd_cmd_t cmd_out;
	ckepd_rx_en_t rx_en;
	logic cmd_oe, cke_oe, odt_oe, dclk_en, pll_run;
	logic [15:0] rnd = 16'h005B;
	int errors = 0;
	int checked = 0;
	int cyc = 0;
	ckepd_note_t q[$];
	always #10 clk_sys_in = ~clk_sys_in;
	ckepd_sequencer ckepd_sequencer_i (.clk_sys_in(clk_sys_in), .reset_in(reset_in), .ck_level_in(ck_level),
		.power_down_enable_bit_in(pd_en), .termination_select_bit_in(term_on), .cmd_in(cmd_in),
		.cmd_out(cmd_out), .cmd_oe_out(cmd_oe), .cke_oe_out(cke_oe), .odt_oe_out(odt_oe),
		.dram_clock_en_out(dclk_en), .rx_en_out(rx_en), .pll_run_out(pll_run));
	ckepd_ctrl_model ckepd_ctrl_model_i (.clk_sys_in(clk_sys_in), .cmd_out(cmd_in), .ck_level_out(ck_level));
	function automatic logic [15:0] lfsr(input logic [15:0] x);
		return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
	endfunction
	task automatic chk(input logic [38:0] seen, input logic [38:0] want);
		checked++;
		if (seen !== want)
		begin
			errors++;
			$display("BAD t=%0t seen=%h want=%h", $time, seen, want);
		end
	endtask
	task automatic report_and_stop;
		$display("errors=%0d checked=%0d", errors, checked);
		if (errors == 0 && checked > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task automatic note(input int d, input ckepd_cmd_t c, input logic oe, input logic [3:0] rx,
		input logic [3:0] lo, input logic [38:0] m);
		q.push_back('{cyc + d, {c, oe, rx, lo}, m});
	endtask
	task automatic tick;
		@(posedge clk_sys_in);
		#1;
	endtask
	task automatic traffic(input int n, input logic [1:0] cke);
		ckepd_cmd_t c;
		repeat (n)
		begin
			rnd = lfsr(rnd);
			c = {4'hF, rnd[1:0], cke, rnd, rnd[5:0]};
			// never two selects low, that would be a control word access
			if (rnd[15])
				c.chip_select[rnd[3:2]] = 1'b0;
			ckepd_ctrl_model_i.put(c);
			note(1, c, 1'b1, 4'hF, 4'hF, M_ALL);
			tick;
		end
	endtask
	task automatic power_cycle(input logic t, input logic stop);
		ckepd_cmd_t c;
		term_on = t;
		traffic(2, 2'b11);
		c = cmd_in;
		c.cke = 2'b00;
		c.chip_select = 4'hE;
		ckepd_ctrl_model_i.put(c);
		note(1, c, 1'b1, 4'hF, 4'hF, M_CKE | M_CS);
		note(2, c, 1'b0, 4'h0, 4'hF, 39'h100);
		note(5, c, 1'b1, 4'h4, 4'hF, M_CKE | 39'h0C0);
		note(6, c, 1'b0, 4'h0, 4'hF, 39'h140);
		c.odt = 2'b00;
		note(6, c, 1'b0, {2'b00, t, t}, 4'hF, M_CKE | 39'h1FF | (t ? 39'h0 : M_ODT));
		tick;
		c.chip_select = 4'hF;
		c.address = ~c.address;
		ckepd_ctrl_model_i.put(c);
		repeat (6) tick;
		if (stop)
		begin
			ckepd_ctrl_model_i.stop_clock(14);
			note(1, c, 1'b0, 4'h0, 4'h1, M_CKE | 39'h10F);
			tick;
			ckepd_ctrl_model_i.wake(24);
			note(1, c, 1'b0, 4'h0, 4'hF, M_CKE | 39'h10F);
			tick;
		end
		c.cke = 2'b01;
		c.odt = 2'b11;
		ckepd_ctrl_model_i.put(c);
		c.odt = t ? 2'b11 : 2'b00;
		note(1, c, 1'b1, 4'hF, 4'hF, M_CKE | M_CS | M_ODT | 39'h10F);
		tick;
		c.chip_select = 4'hB;
		ckepd_ctrl_model_i.put(c);
		note(1, c, 1'b1, 4'hF, 4'hF, M_CKE | M_CS);
		tick;
		c.chip_select = 4'hF;
		ckepd_ctrl_model_i.put(c);
		repeat (9) tick;
		traffic(4, 2'b11);
	endtask
	always @(posedge clk_sys_in)
	begin
		cyc++;
		#2;
		while (q.size() > 0 && q[0].due <= cyc)
		begin
			chk({cmd_out, cmd_oe, rx_en, pll_run, odt_oe, dclk_en, cke_oe} & q[0].m, q[0].v & q[0].m);
			void'(q.pop_front());
		end
	end
	initial
	begin
		repeat (8) @(posedge clk_sys_in);
		#1;
		reset_in = 1'b0;
		repeat (2) tick;
		traffic(20, 2'b11);
		pd_en = 1'b0;
		traffic(3, 2'b00);
		traffic(2, 2'b11);
		pd_en = 1'b1;
		power_cycle(1'b0, 1'b0);
		power_cycle(1'b1, 1'b0);
		power_cycle(1'b0, 1'b1);
		traffic(1, 2'b00);
		repeat (6) tick;
		reset_in = 1'b1;
		tick;
		reset_in = 1'b0;
		repeat (2) tick;
		traffic(6, 2'b11);
		for (int i = 0; i < 50 && q.size() > 0; i++)
			tick;
		if (q.size() > 0)
			errors++;
		report_and_stop;
	end
endmodule
`default_nettype wire
